/* File: hdl/i2c_stop_restart_control.sv */
// Purpose: stop condition, restart bus release and interface enable
// Assumes: registers over AXI4-Lite on clock; bus logic on link_clock
// Notes:   open-drain pins as input, output and output enable
//
// How it works
// - busy plus stop write starts stop sequence
// - stop waits while SCL held low
// - SDA released high with SCL high
// - restart write frees SDA then SCL
// - restart release makes no stop condition
// - master returns high level before restart
// - enable register: bit 7 only, rest zero
// - disabled interface idles the sequencer and pin drives; bus watch keeps tracking busy and last bit
// - disabling keeps every register setting
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module i2c_stop_restart_control
(
  // system
  input  wire logic        clock,
  input  wire logic        rst,
  // link
  input  wire logic        link_clock,
  // axi write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // axi read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // scl pin
  input  wire logic        scl_in,
  output var  logic        scl_out,
  output var  logic        scl_oe,
  // sda pin
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe
);

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a[7:2] == off[7:2]);
  endfunction

  // system domain state
  logic                             interface_enable;
  logic                             master_select;
  logic                             transmit;
  logic                             bus_busy_req;
  logic                             release_bit;
  logic                             cmd_toggle;
  i2c_stop_restart_pkg::cmd_kind_t  cmd_kind;
  logic [7:0]                       aw_addr;
  logic                             aw_have;
  logic [31:0]                      w_data;
  logic [3:0]                       w_strb;
  logic                             w_have;
  logic                             rd_sel_enable;
  logic                             st_busy;
  logic                             st_last_bit;
  logic                             st_scl;
  logic                             st_sda;
  // link domain state
  i2c_stop_restart_pkg::link_state_t state;
  i2c_stop_restart_pkg::link_state_t next_state;
  logic                             link_rst;
  logic                             link_en;
  logic                             cmd_tog_s;
  logic                             cmd_tog_seen;
  logic                             scl_s;
  logic                             sda_s;
  logic                             scl_prev;
  logic                             sda_prev;
  logic                             busy;
  logic                             last_bit;
  // decode
  logic                             do_write;
  logic                             wr_enable;
  logic                             wr_bus;
  logic                             stop_req;
  logic                             release_req;
  logic                             cmd_edge;

  assign do_write  = aw_have && w_have && !s_axi_bvalid;
  assign wr_enable = do_write && w_strb[0]
                     && addr_is(aw_addr, i2c_stop_restart_pkg::ENABLE_CONTROL_OFF);
  assign wr_bus    = do_write && w_strb[0] && interface_enable
                     && addr_is(aw_addr, i2c_stop_restart_pkg::BUS_CONTROL_OFF);
  assign stop_req  = wr_bus && st_busy
                     && w_data[i2c_stop_restart_pkg::MASTER_SELECT_BIT]
                     && w_data[i2c_stop_restart_pkg::TRX_BIT]
                     && w_data[i2c_stop_restart_pkg::PIN_BIT]
                     && !w_data[i2c_stop_restart_pkg::BUS_BUSY_BIT];
  assign release_req = wr_bus && master_select
                     && !w_data[i2c_stop_restart_pkg::MASTER_SELECT_BIT]
                     && !w_data[i2c_stop_restart_pkg::TRX_BIT]
                     && !w_data[i2c_stop_restart_pkg::BUS_BUSY_BIT]
                     && w_data[i2c_stop_restart_pkg::PIN_BIT];

  // axi write channels
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        aw_have       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (do_write)
        aw_have <= 1'b0;
      else if (!aw_have && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_have       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (do_write)
        w_have <= 1'b0;
      else if (!w_have && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
    end
  end

  // axi write response
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= i2c_stop_restart_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (addr_is(aw_addr, i2c_stop_restart_pkg::ENABLE_CONTROL_OFF)
                       || addr_is(aw_addr, i2c_stop_restart_pkg::BUS_CONTROL_OFF)
                       || addr_is(aw_addr, i2c_stop_restart_pkg::BUS_STATUS_OFF))
                      ? i2c_stop_restart_pkg::RESP_OKAY : i2c_stop_restart_pkg::RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // enable register
  always_ff @(posedge clock)
  begin
    if (rst)
      interface_enable <= i2c_stop_restart_pkg::ENABLE_RST;
    else if (wr_enable)
      interface_enable <= w_data[i2c_stop_restart_pkg::ENABLE_BIT];
  end

  // bus control fields, kept while disabled
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      master_select <= i2c_stop_restart_pkg::MASTER_SELECT_RST;
      transmit      <= i2c_stop_restart_pkg::TRX_RST;
      bus_busy_req  <= i2c_stop_restart_pkg::BUS_BUSY_RST;
      release_bit   <= i2c_stop_restart_pkg::PIN_RST;
    end
    else if (wr_bus)
    begin
      master_select <= w_data[i2c_stop_restart_pkg::MASTER_SELECT_BIT];
      transmit      <= w_data[i2c_stop_restart_pkg::TRX_BIT];
      bus_busy_req  <= w_data[i2c_stop_restart_pkg::BUS_BUSY_BIT];
      release_bit   <= w_data[i2c_stop_restart_pkg::PIN_BIT];
    end
  end

  // command toward the link, kind held stable across the toggle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cmd_toggle <= 1'b0;
      cmd_kind   <= i2c_stop_restart_pkg::CMD_STOP;
    end
    else if (stop_req || release_req)
    begin
      cmd_toggle <= !cmd_toggle;
      cmd_kind   <= stop_req ? i2c_stop_restart_pkg::CMD_STOP
                             : i2c_stop_restart_pkg::CMD_RELEASE;
    end
  end

  // axi read
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= i2c_stop_restart_pkg::RDATA_RST;
      s_axi_rresp   <= i2c_stop_restart_pkg::RESP_OKAY;
      rd_sel_enable <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      rd_sel_enable <= addr_is(s_axi_araddr, i2c_stop_restart_pkg::ENABLE_CONTROL_OFF);
      s_axi_rresp   <= i2c_stop_restart_pkg::RESP_OKAY;
      if (addr_is(s_axi_araddr, i2c_stop_restart_pkg::ENABLE_CONTROL_OFF))
        s_axi_rdata <= {24'h000000, interface_enable, 7'h00};
      else if (addr_is(s_axi_araddr, i2c_stop_restart_pkg::BUS_CONTROL_OFF))
        s_axi_rdata <= {24'h000000, master_select, transmit, bus_busy_req, release_bit, 4'h0};
      else if (addr_is(s_axi_araddr, i2c_stop_restart_pkg::BUS_STATUS_OFF))
        s_axi_rdata <= {24'h000000, master_select, transmit, st_busy, release_bit,
                        1'b0, st_sda, st_scl, st_last_bit};
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= i2c_stop_restart_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // crossings
  level_sync #(.WIDTH(i2c_stop_restart_pkg::TO_LINK_W)) to_link
  (
    .clock (link_clock),
    .d     ({rst, interface_enable, cmd_toggle, scl_in, sda_in}),
    .q     ({link_rst, link_en, cmd_tog_s, scl_s, sda_s})
  );

  level_sync #(.WIDTH(i2c_stop_restart_pkg::TO_SYS_W)) to_sys
  (
    .clock (clock),
    .d     ({busy, last_bit, scl_s, sda_s}),
    .q     ({st_busy, st_last_bit, st_scl, st_sda})
  );

  assign cmd_edge = (cmd_tog_s != cmd_tog_seen);

  // link sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      i2c_stop_restart_pkg::ST_IDLE:
        if (cmd_edge)
          next_state = (cmd_kind == i2c_stop_restart_pkg::CMD_STOP)
                       ? i2c_stop_restart_pkg::ST_STOP_PREP
                       : i2c_stop_restart_pkg::ST_REL_SDA;
      i2c_stop_restart_pkg::ST_STOP_PREP: next_state = i2c_stop_restart_pkg::ST_STOP_LOW;
      i2c_stop_restart_pkg::ST_STOP_LOW:  next_state = i2c_stop_restart_pkg::ST_STOP_WAIT;
      i2c_stop_restart_pkg::ST_STOP_WAIT:
        if (scl_s)
          next_state = i2c_stop_restart_pkg::ST_STOP_END;
      i2c_stop_restart_pkg::ST_STOP_END:  next_state = i2c_stop_restart_pkg::ST_IDLE;
      i2c_stop_restart_pkg::ST_REL_SDA:   next_state = i2c_stop_restart_pkg::ST_REL_SCL;
      i2c_stop_restart_pkg::ST_REL_SCL:   next_state = i2c_stop_restart_pkg::ST_IDLE;
      default:                            next_state = i2c_stop_restart_pkg::ST_IDLE;
    endcase
    if (!link_en)
      next_state = i2c_stop_restart_pkg::ST_IDLE;
  end

  // link sequencer state
  always_ff @(posedge link_clock)
  begin
    if (link_rst)
    begin
      state        <= i2c_stop_restart_pkg::ST_IDLE;
      cmd_tog_seen <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      cmd_tog_seen <= cmd_tog_s;
    end
  end

  // pin drives from the coming state
  always_ff @(posedge link_clock)
  begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
    if (link_rst)
    begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      scl_oe <= (next_state == i2c_stop_restart_pkg::ST_STOP_PREP)
                || (next_state == i2c_stop_restart_pkg::ST_STOP_LOW)
                || (next_state == i2c_stop_restart_pkg::ST_REL_SDA);
      sda_oe <= (next_state == i2c_stop_restart_pkg::ST_STOP_LOW)
                || (next_state == i2c_stop_restart_pkg::ST_STOP_WAIT);
    end
  end

  // bus watch: busy flag and last received bit
  always_ff @(posedge link_clock)
  begin
    if (link_rst)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      busy     <= 1'b0;
      last_bit <= 1'b0;
    end
    else
    begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
      if (scl_s && scl_prev && sda_prev && !sda_s)
        busy <= 1'b1;
      else if ((scl_s && scl_prev && !sda_prev && sda_s)
               || (state == i2c_stop_restart_pkg::ST_REL_SCL))
        busy <= 1'b0;
      if (scl_s && !scl_prev)
        last_bit <= sda_s;
    end
  end

  // checks
  a_stop_launch: assert property (@(posedge clock) disable iff (rst)
    stop_req |=> (cmd_toggle != $past(cmd_toggle)) && (cmd_kind == i2c_stop_restart_pkg::CMD_STOP))
    else $error("stop write did not launch stop");
  a_stop_waits_scl: assert property (@(posedge link_clock) disable iff (link_rst)
    (state == i2c_stop_restart_pkg::ST_STOP_WAIT) && !scl_s && link_en
    |=> (state == i2c_stop_restart_pkg::ST_STOP_WAIT) && sda_oe && !scl_oe)
    else $error("stop went on while scl low");
  a_stop_sda_high: assert property (@(posedge link_clock) disable iff (link_rst)
    (state == i2c_stop_restart_pkg::ST_STOP_WAIT) && scl_s && link_en
    |=> !sda_oe && !scl_oe ##1 (state == i2c_stop_restart_pkg::ST_IDLE))
    else $error("sda not released after scl high");
  a_release_order: assert property (@(posedge link_clock) disable iff (link_rst)
    (state == i2c_stop_restart_pkg::ST_REL_SDA) && link_en
    |=> (state == i2c_stop_restart_pkg::ST_REL_SCL) && !scl_oe && !sda_oe)
    else $error("restart release order wrong");
  a_release_no_stop: assert property (@(posedge link_clock) disable iff (link_rst)
    (state == i2c_stop_restart_pkg::ST_REL_SDA) |-> scl_oe && !sda_oe)
    else $error("sda freed with scl high");
  a_enable_readback: assert property (@(posedge clock) disable iff (rst)
    s_axi_rvalid && rd_sel_enable |-> s_axi_rdata == {24'h000000, interface_enable, 7'h00})
    else $error("enable register read wrong");
  a_disabled_idle: assert property (@(posedge link_clock) disable iff (link_rst)
    !link_en |=> (state == i2c_stop_restart_pkg::ST_IDLE) && !scl_oe && !sda_oe)
    else $error("bus logic active while disabled");
  a_settings_kept: assert property (@(posedge clock) disable iff (rst)
    !interface_enable |=> $stable(master_select) && $stable(transmit) && $stable(release_bit))
    else $error("settings changed while disabled");
  a_idle_master_ignored: assert property (@(posedge clock) disable iff (rst)
    wr_bus && !master_select && !w_data[i2c_stop_restart_pkg::MASTER_SELECT_BIT]
    |=> $stable(cmd_toggle))
    else $error("restart from idle master");

  c_stop_done: cover property (@(posedge link_clock) disable iff (link_rst)
    state == i2c_stop_restart_pkg::ST_STOP_END);
  c_release_done: cover property (@(posedge link_clock) disable iff (link_rst)
    state == i2c_stop_restart_pkg::ST_REL_SCL);
  c_enable_on: cover property (@(posedge clock) disable iff (rst)
    $rose(interface_enable));
  c_stop_stall: cover property (@(posedge link_clock) disable iff (link_rst)
    (state == i2c_stop_restart_pkg::ST_STOP_WAIT) && !scl_s);

endmodule // i2c_stop_restart_control

`default_nettype wire

/* File: inc/i2c_stop_restart_pkg.sv */
// Purpose: shared constants and types for the stop/restart control block
// Assumes: 32-bit AXI4-Lite register access, byte offsets below
// Notes:   bus control bits sit in byte 0 of their registers
`default_nettype none

package i2c_stop_restart_pkg;

  // register map
  localparam int          ADDR_W             = 8;
  localparam logic [7:0]  ENABLE_CONTROL_OFF = 8'h00;
  localparam logic [7:0]  BUS_CONTROL_OFF    = 8'h04;
  localparam logic [7:0]  BUS_STATUS_OFF     = 8'h08;

  // field positions
  localparam int ENABLE_BIT        = 7;
  localparam int MASTER_SELECT_BIT = 7;
  localparam int TRX_BIT           = 6;
  localparam int BUS_BUSY_BIT      = 5;
  localparam int PIN_BIT           = 4;
  localparam int SDA_LVL_BIT       = 2;
  localparam int SCL_LVL_BIT       = 1;
  localparam int LAST_RX_BIT       = 0;

  // values after reset
  localparam logic        ENABLE_RST        = 1'h0;
  localparam logic        MASTER_SELECT_RST = 1'h0;
  localparam logic        TRX_RST           = 1'h0;
  localparam logic        BUS_BUSY_RST      = 1'h0;
  localparam logic        PIN_RST           = 1'h0;
  localparam logic [31:0] RDATA_RST         = 32'h00000000;

  // bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // crossing widths
  localparam int TO_LINK_W = 5;
  localparam int TO_SYS_W  = 4;

  typedef enum logic [6:0]
  {
    ST_IDLE      = 7'h01,
    ST_STOP_PREP = 7'h02,
    ST_STOP_LOW  = 7'h04,
    ST_STOP_WAIT = 7'h08,
    ST_STOP_END  = 7'h10,
    ST_REL_SDA   = 7'h20,
    ST_REL_SCL   = 7'h40
  } link_state_t;

  typedef enum logic [1:0]
  {
    CMD_STOP    = 2'h1,
    CMD_RELEASE = 2'h2
  } cmd_kind_t;

endpackage

`default_nettype wire

/* File: hdl/level_sync.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: inputs are levels that stay long enough to be seen
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module level_sync
#(
  parameter int WIDTH = 1
)
(
  // clock
  input  wire logic             clock,
  // data
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock)
  begin
    stage1 <= d;
    q      <= stage1;
  end

endmodule // level_sync

`default_nettype wire

/* File: tb/i2c_bus_partner.sv */
// Purpose: other masters and slaves on the two-wire bus
// Assumes: open-drain lines with pull-ups, bench commands as levels
// Notes:   a start_req rise gives a start and one clock pulse, sda high
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_partner
(
  // clock and reset
  input  wire logic link_clock,
  input  wire logic rst,
  // device pulls
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // bench commands
  input  wire logic start_req,
  input  wire logic hold_scl,
  // resolved wires
  output var  logic scl_wire,
  output var  logic sda_wire
);
  logic [1:0] step;
  logic       req_q;
  logic       pull_scl;
  logic       pull_sda;

  // start, clock low, sda freed, clock freed
  assign pull_sda = (step == 2'h1) || (step == 2'h2);
  assign pull_scl = (step == 2'h2) || (step == 2'h3);

  // wired-and with pull-ups
  always_comb
  begin
    scl_wire = !(scl_oe || pull_scl || hold_scl);
    sda_wire = !(sda_oe || pull_sda);
  end

  // step through the start sequence
  always_ff @(posedge link_clock)
  begin
    req_q <= start_req;
    if (rst)
      step <= 2'h0;
    else if (step != 2'h0)
      step <= step + 2'h1;
    else if (start_req && !req_q)
      step <= 2'h1;
  end
endmodule // i2c_bus_partner

`default_nettype wire

/* File: tb/i2c_stop_restart_control_tb.sv */
// Purpose: self-checking bench for stop, restart and enable control
// Assumes: AXI4-Lite master tasks, partner on the two-wire bus
// Notes:   register model kept in plain variables
`timescale 1ns/1ps
`default_nettype none
`define check_eq(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module i2c_stop_restart_control_tb;
  logic        clock = 1'b0;
  logic        link_clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        scl_out, scl_oe, sda_out, sda_oe, scl_wire, sda_wire;
  logic        start_req = 1'b0, hold_scl = 1'b0;
  logic [31:0] en_m = 32'h0, rv;
  logic [7:0]  ctrl_m = 8'h00;
  int          err_total = 0, checks = 0, stop_cnt = 0, oe_rises = 0, n0;
  localparam logic [31:0] ST_MASK = 32'h00000027;

  always #4 clock = ~clock;
  initial
  begin
    #3;
    forever #32 link_clock = ~link_clock;
  end

  i2c_stop_restart_control dut
  (
    .clock(clock), .rst(rst), .link_clock(link_clock),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .scl_in(scl_wire), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe)
  );

  i2c_bus_partner partner
  (
    .link_clock(link_clock), .rst(rst), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .start_req(start_req), .hold_scl(hold_scl), .scl_wire(scl_wire), .sda_wire(sda_wire)
  );

  // wire events
  always @(posedge sda_wire) if (scl_wire === 1'b1) stop_cnt++;
  always @(posedge scl_oe) oe_rises++;

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 200)
    begin
      @(posedge clock);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && !s_axi_awvalid && !s_axi_wvalid)
      begin
        r = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
    if (n >= 200) err_total++;
    @(posedge clock);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    d = 32'h0;
    r = 2'h3;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 200)
    begin
      @(posedge clock);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && !s_axi_arvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
    if (n >= 200) err_total++;
    @(posedge clock);
  endtask

  // write and keep the register model in step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, r);
    `check_eq("bresp", er, r)
    if (s_axi_wstrb[0] && a == i2c_stop_restart_pkg::ENABLE_CONTROL_OFF)
      en_m = {24'h0, d[7], 7'h0};
    if (s_axi_wstrb[0] && a == i2c_stop_restart_pkg::BUS_CONTROL_OFF && en_m[7])
      ctrl_m = {d[7:4], 4'h0};
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    logic [1:0] r;
    axi_read(a, rv, r);
    `check_eq("rresp", er, r)
    `check_eq("rdata", e & m, rv & m)
  endtask

  task automatic wait_link(input int n);
    repeat (n) @(posedge link_clock);
    @(posedge clock);
  endtask

  // poll one status bit for a value, bounded
  task automatic poll(input int b, input logic v);
    logic [1:0] r;
    for (int i = 0; i < 100; i++)
    begin
      axi_read(i2c_stop_restart_pkg::BUS_STATUS_OFF, rv, r);
      if (rv[b] === v) break;
    end
    `check_eq("status bit", v, rv[b])
  endtask

  task automatic start_pulse();
    start_req <= 1'b1;
    wait_link(3);
    start_req <= 1'b0;
    wait_link(6);
  endtask

  task automatic end_sim();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    err_total++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h070C));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    wait_link(6);
    // reset values, unmapped place, disabled control write
    rd(8'h00, 32'hFFFFFFFF, 32'h0, 2'h0);
    rd(8'h04, 32'hFFFFFFFF, 32'h0, 2'h0);
    rd(8'h08, ST_MASK, 32'h00000006, 2'h0);
    rd(8'h0C, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(8'h0C, 32'h00000080, 2'h2);
    wr(8'h08, 32'h000000FF, 2'h0);
    s_axi_wstrb <= 4'hE;
    wr(8'h00, 32'h00000080, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h00, 32'hFFFFFFFF, en_m, 2'h0);
    wr(8'h04, 32'h000000C0, 2'h0);
    rd(8'h04, 32'hFFFFFFFF, {24'h0, ctrl_m}, 2'h0);
    $display("test reset done");
    // random enable writes
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h00, $urandom, 2'h0);
      rd(8'h00, 32'hFFFFFFFF, en_m, 2'h0);
    end
    wr(8'h00, 32'hFFFFFFFF, 2'h0);
    wr(8'h04, 32'h000000C0, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'hFFFFFFFF, {24'h0, ctrl_m}, 2'h0);
    wr(8'h00, 32'h00000080, 2'h0);
    $display("test enable done");
    // stop held off by scl, then disable mid-sequence
    start_pulse();
    poll(i2c_stop_restart_pkg::BUS_BUSY_BIT, 1'b1);
    n0 = stop_cnt;
    hold_scl <= 1'b1;
    wr(8'h04, 32'h000000D0, 2'h0);
    wait_link(20);
    `check_eq("sda held", 1'b0, sda_wire)
    `check_eq("pin level", 2'h0, {scl_out, sda_out})
    `check_eq("stops", n0, stop_cnt)
    wr(8'h00, 32'h0, 2'h0);
    wait_link(6);
    `check_eq("scl_oe off", 1'b0, scl_oe)
    `check_eq("sda_oe off", 1'b0, sda_oe)
    hold_scl <= 1'b0;
    wr(8'h00, 32'h00000080, 2'h0);
    rd(8'h04, 32'hFFFFFFFF, {24'h0, ctrl_m}, 2'h0);
    $display("test disable done");
    // full stop after scl released
    start_pulse();
    poll(i2c_stop_restart_pkg::BUS_BUSY_BIT, 1'b1);
    n0 = stop_cnt;
    hold_scl <= 1'b1;
    wr(8'h04, 32'h000000D0, 2'h0);
    wait_link(12);
    `check_eq("stops held", n0, stop_cnt)
    hold_scl <= 1'b0;
    wait_link(12);
    `check_eq("stops", n0 + 1, stop_cnt)
    poll(i2c_stop_restart_pkg::BUS_BUSY_BIT, 1'b0);
    n0 = oe_rises;
    wr(8'h04, 32'h000000D0, 2'h0);
    wait_link(12);
    `check_eq("idle pins", n0, oe_rises)
    $display("test stop done");
    // restart bus release
    start_pulse();
    poll(i2c_stop_restart_pkg::BUS_BUSY_BIT, 1'b1);
    n0 = stop_cnt;
    wr(8'h04, 32'h00000010, 2'h0);
    poll(i2c_stop_restart_pkg::BUS_BUSY_BIT, 1'b0);
    poll(i2c_stop_restart_pkg::LAST_RX_BIT, 1'b1);
    `check_eq("no stop", n0, stop_cnt)
    `check_eq("scl free", 1'b1, scl_wire)
    `check_eq("sda high", 1'b1, sda_wire)
    hold_scl <= 1'b1;
    wait_link(4);
    poll(i2c_stop_restart_pkg::SCL_LVL_BIT, 1'b0);
    hold_scl <= 1'b0;
    repeat (588) @(posedge clock);
    start_pulse();
    poll(i2c_stop_restart_pkg::BUS_BUSY_BIT, 1'b1);
    n0 = oe_rises;
    wr(8'h04, 32'h00000010, 2'h0);
    wait_link(12);
    `check_eq("second release", n0, oe_rises)
    $display("test restart done");
    end_sim();
  end
endmodule // i2c_stop_restart_control_tb

`default_nettype wire
